/* dv/init_table_model.sv */
// shared memory model holding the status and mask words of the table
`timescale 1ns/1ps
module init_table_model (
	input wire clk_i,
	input wire reset_i,
	input wire req_i,
	input wire we_i,
	input wire [7:0] addr_i,
	input wire [15:0] wdata_i,
	output wire [15:0] rdata_o,
	output reg ack_o
);
	reg [15:0] words [0:3];
	reg [15:0] rd_reg;
	reg [1:0] wait_reg;
	integer seed;
	initial begin
		seed = 28330;
		ack_o = 1'b0;
		rd_reg = 16'h0000;
		wait_reg = 2'h0;
		for (seed = 0; seed < 4; seed = seed + 1) words[seed] = 16'h0000;
		seed = 28330;
	end
	// off the answer cycle the bus shows the inverse, so stale data never passes
	assign rdata_o = ack_o ? rd_reg : ~rd_reg;
	// one answer per transfer after a random wait of zero to two cycles
	always @(posedge clk_i) begin
		ack_o <= 1'b0;
		if (reset_i) begin
			wait_reg <= 2'h0;
		end else if (req_i && !ack_o) begin
			if (wait_reg == 2'h0) begin
				ack_o <= 1'b1;
				wait_reg <= 2'({$random(seed)} % 3);
				if (we_i) words[addr_i[2:1]] <= wdata_i;
				else rd_reg <= words[addr_i[2:1]];
			end else begin
				wait_reg <= wait_reg - 2'h1;
			end
		end
	end
endmodule

/* dv/token_bus_event_flags_bench.sv */
// self-checking bench for the token bus event flag block
`timescale 1ns/1ps
module token_bus_event_flags_bench;
	reg clk_i;
	reg reset_i;
	reg [40:0] ev;
	reg [40:0] lv;
	reg [40:0] pl;
	reg [47:0] own_station_address_i, frame_src_addr_i, successor_new_i, set_successor_data_i;
	reg [15:0] stat_counter_value_i, stat_threshold_i;
	reg [15:0] sh [0:1];
	reg [15:0] mk [0:1];
	reg [23:0] q [$];
	reg [23:0] wexp;
	reg ei;
	integer seed, error_cnt, num_checks, r, k, i;
	wire mem_req_o, mem_we_o, mem_ack_i, irq_o, go_offline_o, go_idle_o, solicit_any_send_o;
	wire class6_start_o, response_window_open_o;
	wire [7:0] mem_addr_o;
	wire [15:0] mem_wdata_o, mem_rdata_i;
	wire [47:0] successor_addr_o;
	// events and qualifiers share one vector so scenarios name them by bit
	wire clear_status_i = ev[0], iack_i = ev[1], tx_frame_done_i = ev[2], tx_frame_is_special_i = ev[3];
	wire rx_accept_i = ev[4], rx_is_rwr_i = ev[5], rx_error_i = ev[6], rx_retry_i = ev[7];
	wire rwr_pointer_written_i = ev[8], ctl_frame_rx_i = ev[9], frame_is_echo_i = ev[10];
	wire contention_fail_i = ev[11], ring_entered_i = ev[12], solicit_ok_i = ev[13], successor_update_i = ev[14];
	wire set_successor_rx_i = ev[15], token_pass_failed_i = ev[16], idle_from_offline_i = ev[17];
	wire awaiting_response_i = ev[18], valid_frame_rx_i = ev[19], frame_is_response_to_us_i = ev[20];
	wire solicit_any_reached_i = ev[21], awaiting_solicit_i = ev[22], data_frame_rx_i = ev[23];
	wire frame_is_own_i = ev[24], frame_to_us_i = ev[25], claim_rx_i = ev[26], claim_won_i = ev[27];
	wire class6_done_i = ev[28], bus_idle_expired_i = ev[29], frames_pending_i = ev[30];
	wire in_ring_desired_i = ev[31], sole_active_i = ev[32], stat_counter_incr_i = ev[33], claim_lost_i = ev[34];
	wire claim_after_silence_i = ev[35], modem_error_pin_i = ev[36], state_idle_i = ev[37];
	wire state_use_token_i = ev[38], ext_loop_test_i = ev[39], await_response_timeout_i = ev[40];

	token_bus_event_flags token_bus_event_flags_i (.*);
	init_table_model init_table_model_i (.clk_i(clk_i), .reset_i(reset_i), .req_i(mem_req_o), .we_i(mem_we_o),
		.addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	function [40:0] b(input integer n);
		b = 41'h1 << n;
	endfunction

	task chk(input [8*10-1:0] nm, input [47:0] e, input [47:0] g);
		begin
			num_checks = num_checks + 1;
			if (g !== e) begin
				error_cnt = error_cnt + 1;
				$display("[ERR] %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask

	task finish_test;
		begin
			$display("checks %0d errors %0d", num_checks, error_cnt);
			if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
			else $display("SIMULATION FAILED");
			$finish;
		end
	endtask

	// note the status write a fresh flag must cause, and its interrupt
	task want(input integer w, input integer n);
		begin
			if (sh[w][n] === 1'b0) begin
				q.push_back({(w == 1) ? 8'hac : 8'ha8, sh[w] | (16'h1 << n)});
				ei = mk[w][n];
			end
			sh[w][n] = 1'b1;
		end
	endtask

	// bounded wait for the device to finish its table sequence, if any
	task settle;
		begin
			for (i = 0; i < 12 && mem_req_o !== 1'b1; i = i + 1) @(negedge clk_i);
			for (i = 0; i < 80 && mem_req_o === 1'b1; i = i + 1) @(negedge clk_i);
			if (mem_req_o !== 1'b0) begin
				error_cnt = error_cnt + 1;
				$display("[ERR] sequence end expected 0 seen %b", mem_req_o);
				finish_test;
			end
		end
	endtask

	// qualifiers held through the sequence, events pulsed one cycle, then vector fetch
	task step(input [40:0] l, input [40:0] p, input integer w, input integer n);
		begin
			ei = 1'b0;
			if (w >= 0) want(w, n);
			@(negedge clk_i);
			ev = l | p;
			@(negedge clk_i);
			ev = l;
			settle;
			ev = 41'h0;
			chk("irq", {47'h0, ei}, {47'h0, irq_o});
			@(negedge clk_i);
			ev = b(1);
			@(negedge clk_i);
			ev = 41'h0;
		end
	endtask

	task clear_all;
		begin
			q.push_back({8'ha8, 16'h0000});
			q.push_back({8'hac, 16'h0000});
			sh[0] = 16'h0000;
			sh[1] = 16'h0000;
			step(41'h0, b(0), -1, 0);
		end
	endtask

	// every table write is matched against the oldest noted expectation
	always @(posedge clk_i) begin
		if (mem_req_o === 1'b1 && mem_we_o === 1'b1 && mem_ack_i === 1'b1) begin
			if (q.size() == 0) begin
				error_cnt = error_cnt + 1;
				$display("[ERR] write expected none seen %h", {mem_addr_o, mem_wdata_o});
			end else begin
				wexp = q.pop_front();
				chk("write", {24'h0, wexp}, {24'h0, mem_addr_o, mem_wdata_o});
			end
		end
	end

	initial begin
		seed = 28330;
		ev = 41'h0;
		reset_i = 1'b1;
		error_cnt = 0;
		num_checks = 0;
		own_station_address_i = {16'h5a3c, $random(seed)};
		frame_src_addr_i = own_station_address_i;
		set_successor_data_i = own_station_address_i;
		successor_new_i = 48'h0;
		stat_threshold_i = 16'h0010;
		stat_counter_value_i = 16'h0011;
		sh[0] = 16'h0000;
		sh[1] = 16'h0000;
		repeat (16) @(negedge clk_i);
		reset_i = 1'b0;
		mk[0] = 16'($random(seed));
		init_table_model_i.words[1] = mk[0];
		// blocked events must leave the table alone
		step(b(10), b(9), -1, 0);
		step(b(18) | b(20), b(19), -1, 0);
		step(b(22) | b(24), b(23), -1, 0);
		step(b(24), b(26), -1, 0);
		step(b(30), b(29), -1, 0);
		step(b(31), b(29), -1, 0);
		step(41'h0, b(34), -1, 0);
		step(41'h0, b(36), -1, 0);
		// every ring event but faulty transmitter: fresh, repeated with flag set, fresh again after a clear
		for (r = 0; r < 3; r = r + 1) begin
			mk[1] = 16'($random(seed));
			init_table_model_i.words[3] = mk[1];
			if (r == 2) clear_all;
			for (k = 0; k < 16; k = k + 1) begin
				lv = 41'h0;
				case (k)
					0: pl = b(9);
					2: begin
						successor_new_i = {16'h0, $random(seed)};
						pl = b(14);
					end
					3: pl = b((r == 2) ? 17 : 16);
					4: pl = b(15);
					5: begin lv = b(18); pl = b(19); end
					6: pl = b(21);
					7: begin lv = b(22); pl = b(23); end
					8: pl = b(26);
					9: pl = b(40);
					10: pl = b(27);
					11: begin lv = (r == 2) ? (b(31) | b(32)) : 41'h0; pl = b(29); end
					12: pl = b(33);
					13: begin lv = b(35); pl = b(34); end
					default: begin lv = b(37 + r); pl = b(36); end
				endcase
				if (k != 1 && k != 14) step(lv, pl, 1, k);
				if (k == 2) chk("successor", successor_new_i, successor_addr_o);
				// class 6 done opens the window once after a win, never on a second done
				if (k == 10) begin
					@(negedge clk_i);
					ev = b(28);
					@(negedge clk_i);
					chk("window", 48'h1, {47'h0, response_window_open_o});
					@(negedge clk_i);
					ev = 41'h0;
					chk("window", 48'h0, {47'h0, response_window_open_o});
				end
			end
		end
		// frame completion flags in word 0
		step(b(3), b(2), -1, 0);
		step(41'h0, b(2), 0, 13);
		step(b(5) | b(6), b(4), 0, 15);
		step(41'h0, b(8), -1, 0);
		step(b(5) | b(7), b(4), -1, 0);
		step(b(5), b(4), -1, 0);
		step(41'h0, b(8), 0, 14);
		// fault count: seven failures are silent, the eighth flags; entry and solicit clear it
		for (r = 0; r < 3; r = r + 1) begin
			for (k = 0; k < 8; k = k + 1) step(41'h0, b(11), (k == 7) ? 1 : -1, 1);
			step(41'h0, b(12 + r % 2), -1, 0);
			clear_all;
		end
		if (q.size() != 0) begin
			error_cnt = error_cnt + 1;
			$display("[ERR] writes expected %0d seen 0", q.size());
		end
		finish_test;
	end
endmodule

/* dv/token_bus_event_flags_properties.sv */
// port-level checks for the token bus event flag block
`timescale 1ns/1ps
module token_bus_event_flags_properties #(
	parameter ADDR_W = 48,
	parameter DATA_W = 16
) (
	input wire clk_i,
	input wire reset_i,
	input wire mem_req_o,
	input wire mem_we_o,
	input wire [7:0] mem_addr_o,
	input wire [DATA_W-1:0] mem_wdata_o,
	input wire mem_ack_i,
	input wire iack_i,
	input wire irq_o,
	input wire [ADDR_W-1:0] own_station_address_i,
	input wire [ADDR_W-1:0] frame_src_addr_i,
	input wire ctl_frame_rx_i,
	input wire frame_is_echo_i,
	input wire awaiting_response_i,
	input wire valid_frame_rx_i,
	input wire frame_is_response_to_us_i,
	input wire solicit_any_reached_i,
	input wire claim_won_i,
	input wire go_offline_o,
	input wire go_idle_o,
	input wire solicit_any_send_o,
	input wire class6_start_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// protocol reactions, one cycle after their cause
	property p_dup_offline;
		ctl_frame_rx_i && !frame_is_echo_i && frame_src_addr_i == own_station_address_i |=> go_offline_o;
	endproperty
	a_dup_offline: assert property (p_dup_offline) else $error("duplicate address did not go offline");
	property p_unexp_idle;
		awaiting_response_i && valid_frame_rx_i && !frame_is_response_to_us_i |=> go_idle_o;
	endproperty
	a_unexp_idle: assert property (p_unexp_idle) else $error("unexpected frame did not go idle");
	property p_solicit_send;
		solicit_any_reached_i |=> solicit_any_send_o;
	endproperty
	a_solicit_send: assert property (p_solicit_send) else $error("solicit any frame not sent");
	property p_win_class6;
		claim_won_i |=> class6_start_o;
	endproperty
	a_win_class6: assert property (p_win_class6) else $error("class 6 not started after win");
	// interrupt request stays until the vector fetch
	property p_irq_hold;
		irq_o && !iack_i |=> irq_o;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without acknowledge");
	property p_irq_drop;
		iack_i && !(mem_we_o && mem_ack_i) |=> !irq_o;
	endproperty
	a_irq_drop: assert property (p_irq_drop) else $error("irq stayed after acknowledge");
	property p_irq_cause;
		$rose(irq_o) |-> $past(mem_req_o && mem_we_o && mem_ack_i && mem_wdata_o != 16'h0000);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq without a status write");
	// read-modify-write ordering on the table
	property p_req_stable;
		mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_wdata_o);
	endproperty
	a_req_stable: assert property (p_req_stable) else $error("memory request changed before ack");
	property p_mask_then_write;
		!mem_we_o && mem_ack_i && mem_addr_o == 8'hae |=> mem_req_o && mem_we_o && mem_addr_o == 8'hac;
	endproperty
	a_mask_then_write: assert property (p_mask_then_write) else $error("mask read not followed by write");
	property p_clear_pair;
		$rose(mem_req_o) && mem_we_o |-> mem_addr_o == 8'ha8 && mem_wdata_o == '0
			##[1:4] mem_ack_i ##1 (mem_we_o && mem_addr_o == 8'hac && mem_wdata_o == '0);
	endproperty
	a_clear_pair: assert property (p_clear_pair) else $error("clear did not zero both words");
	c_irq: cover property ($rose(irq_o));
	c_clear: cover property ($rose(mem_req_o) && mem_we_o);
	c_offline: cover property (go_offline_o);
endmodule

bind token_bus_event_flags token_bus_event_flags_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) props_i (.*);

/* hw/token_bus_event_flags.v */
// event flag, mask and interrupt request logic of the token bus access controller
// Functional notes
// R1 - tx data done flag set after an ordinary outgoing frame is finished
// R2 - rx request flag set only after confirmation, queue link and pointer write
// R3 - errored request frame never sets rx request; if accepted sets rx data
// R4 - rx data flag set on accepting ordinary or invalid request frame
// R5 - status word 1 at ac holds the fifteen ring event flags in order
// R6 - own-address control frame that is not our echo: duplicate flag, offline
// R7 - token contention failures count up; above seven set faulty flag, offline
// R8 - fault count cleared on ring entry or successful solicitation
// R9 - successor change sets successor changed flag; address stays readable
// R10 - own address in set-successor sets no successor one; pass fail sets no successor
// R11 - foreign frame while awaiting own response: unexpected six flag, go idle
// R12 - token ignored twice and two queries unanswered: send solicit any, set flag
// R13 - foreign frame during solicitation window: unexpected ten flag, go idle
// R14 - claim token heard from another station sets claim heard flag
// R15 - winning claim sets win flag, sends class 6, then opens window
// R16 - bus idle expiry with nothing to send and no ring need sets flag
// R17 - statistics counter passing nonzero threshold sets threshold flag
// R18 - losing claim after silence sets lose sort flag and returns idle
// R19 - modem error in idle, use token or external loop tests: flag, offline
// R20 - await response ending without answer sets no response flag
// R21 - newly set flag requests interrupt only when its mask bit is one
// R22 - mask word 0 at aa follows the word 0 bit layout
// R23 - mask word 1 at ae follows status word 1 layout, bit 14 reserved
// R24 - flag set by read, set bit, write back; no write if already set
// R25 - host clears status words only through the clear status command
// R26 - interrupt request held until host fetches the vector
`timescale 1ns/1ps
`include "token_bus_event_map.vh"
module token_bus_event_flags #(
	parameter ADDR_W = 48,
	parameter DATA_W = 16
) (
	input wire clk_i,
	input wire reset_i,
	output reg mem_req_o,
	output reg mem_we_o,
	output reg [7:0] mem_addr_o,
	output reg [DATA_W-1:0] mem_wdata_o,
	input wire [DATA_W-1:0] mem_rdata_i,
	input wire mem_ack_i,
	input wire clear_status_i,
	input wire iack_i,
	output reg irq_o,
	input wire tx_frame_done_i,
	input wire tx_frame_is_special_i,
	input wire rx_accept_i,
	input wire rx_is_rwr_i,
	input wire rx_error_i,
	input wire rx_retry_i,
	input wire rwr_pointer_written_i,
	input wire [ADDR_W-1:0] own_station_address_i,
	input wire [ADDR_W-1:0] frame_src_addr_i,
	input wire ctl_frame_rx_i,
	input wire frame_is_echo_i,
	input wire contention_fail_i,
	input wire ring_entered_i,
	input wire solicit_ok_i,
	input wire successor_update_i,
	input wire [ADDR_W-1:0] successor_new_i,
	input wire set_successor_rx_i,
	input wire [ADDR_W-1:0] set_successor_data_i,
	input wire token_pass_failed_i,
	input wire idle_from_offline_i,
	input wire awaiting_response_i,
	input wire valid_frame_rx_i,
	input wire frame_is_response_to_us_i,
	input wire solicit_any_reached_i,
	input wire awaiting_solicit_i,
	input wire data_frame_rx_i,
	input wire frame_is_own_i,
	input wire frame_to_us_i,
	input wire claim_rx_i,
	input wire claim_won_i,
	input wire class6_done_i,
	input wire bus_idle_expired_i,
	input wire frames_pending_i,
	input wire in_ring_desired_i,
	input wire sole_active_i,
	input wire stat_counter_incr_i,
	input wire [15:0] stat_counter_value_i,
	input wire [15:0] stat_threshold_i,
	input wire claim_lost_i,
	input wire claim_after_silence_i,
	input wire modem_error_pin_i,
	input wire state_idle_i,
	input wire state_use_token_i,
	input wire ext_loop_test_i,
	input wire await_response_timeout_i,
	output reg go_offline_o,
	output reg go_idle_o,
	output reg solicit_any_send_o,
	output reg class6_start_o,
	output reg response_window_open_o,
	output reg [ADDR_W-1:0] successor_addr_o
);
	localparam S_IDLE = 3'd0;
	localparam S_RD_STAT = 3'd1;
	localparam S_RD_MASK = 3'd2;
	localparam S_WR_STAT = 3'd3;
	localparam S_CLR0 = 3'd4;
	localparam S_CLR1 = 3'd5;
	// lowest set bit, used for both pending words
	function [3:0] first_set;
		input [15:0] vec;
		integer k;
		begin
			first_set = 4'h0;
			for (k = 15; k >= 0; k = k - 1) begin
				if (vec[k]) begin
					first_set = k[3:0];
				end
			end
		end
	endfunction
	// one-hot of a bit position, used for pending drop and flag merge
	function [15:0] one_hot;
		input [3:0] pos;
		begin
			one_hot = 16'h0001 << pos;
		end
	endfunction
	reg [2:0] state_reg;
	reg [15:0] pend0_reg;
	reg [15:0] pend1_reg;
	reg clr_pend_reg;
	reg word_sel_reg;
	reg [3:0] bit_reg;
	reg [DATA_W-1:0] stat_reg;
	reg mask_bit_reg;
	reg rwr_wait_reg;
	reg class6_wait_reg;
	reg modem_sync1_reg;
	reg modem_sync2_reg;
	reg [15:0] set0;
	reg [15:0] set1;
	reg [15:0] drop0;
	reg [15:0] drop1;
	reg irq_set;
	reg clr_done;
	wire ftx_event;
	// fault counter: fails raise it, ring entry or solicitation clears it
	tx_fault_counter #(.CNT_W(4), .LIMIT(`TX_FAULT_LIMIT)) tx_fault_counter_i (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.fail_i(contention_fail_i), // see R7
		.clear_i(ring_entered_i || solicit_ok_i), // see R8
		.exceeded_o(ftx_event)
	);
	// modem error comes from the physical layer, off our clock
	always @(posedge clk_i) begin
		if (reset_i) begin
			modem_sync1_reg <= 1'b0;
			modem_sync2_reg <= 1'b0;
		end else begin
			modem_sync1_reg <= modem_error_pin_i;
			modem_sync2_reg <= modem_sync1_reg;
		end
	end
	// word 1 event decode, one-cycle strobes from the access machine except the modem error from the synchronized pin
	wire dup_ev = ctl_frame_rx_i && (frame_src_addr_i == own_station_address_i) && !frame_is_echo_i; // see R6
	wire sc_ev = successor_update_i && (successor_new_i != successor_addr_o); // see R9
	wire ns1_ev = set_successor_rx_i && (set_successor_data_i == own_station_address_i); // see R10
	wire ns_ev = token_pass_failed_i || idle_from_offline_i; // see R10
	wire u6_ev = awaiting_response_i && valid_frame_rx_i && !frame_is_response_to_us_i; // see R11
	wire u10_data = data_frame_rx_i && !frame_is_own_i;
	wire u10_setsucc = set_successor_rx_i && !frame_to_us_i;
	wire u10_ctl = ctl_frame_rx_i && !set_successor_rx_i && !frame_is_own_i;
	wire u10_ev = awaiting_solicit_i && (u10_data || u10_setsucc || u10_ctl); // see R13
	wire claim_ev = claim_rx_i && !frame_is_own_i; // see R14
	wire idle_ev = bus_idle_expired_i && !frames_pending_i && (!in_ring_desired_i || sole_active_i); // see R16
	// zero threshold disables the check, counters still run elsewhere
	wire tce_ev = stat_counter_incr_i && (stat_threshold_i != 16'h0000) &&
		(stat_counter_value_i > stat_threshold_i); // see R17
	wire las_ev = claim_lost_i && claim_after_silence_i; // see R18
	wire modem_watch = state_idle_i || state_use_token_i || ext_loop_test_i;
	wire modem_error_flag_ev = modem_sync2_reg && modem_watch; // see R19
	// word 0 frame completion decode
	wire tx_data_done_flag_ev = tx_frame_done_i && !tx_frame_is_special_i; // see R1
	wire rx_valid_rwr = rx_accept_i && rx_is_rwr_i && !rx_error_i && !rx_retry_i;
	wire rx_data_flag_ev = rx_accept_i && (!rx_is_rwr_i || rx_error_i); // see R3, R4
	wire rx_request_flag_ev = rwr_wait_reg && rwr_pointer_written_i; // see R2
	// gather new events into per-word set vectors
	always @* begin
		set0 = 16'h0000;
		set0[`W0_TX_DATA_DONE] = tx_data_done_flag_ev;
		set0[`W0_RX_DATA] = rx_data_flag_ev;
		set0[`W0_RX_REQUEST] = rx_request_flag_ev;
		set1 = 16'h0000;
		set1[`W1_DUPLICATE_ADDRESS] = dup_ev;
		set1[`W1_FAULTY_TRANSMITTER] = ftx_event;
		set1[`W1_SUCCESSOR_CHANGED] = sc_ev;
		set1[`W1_NO_SUCCESSOR] = ns_ev;
		set1[`W1_NO_SUCCESSOR_ONE] = ns1_ev;
		set1[`W1_UNEXPECTED_SIX] = u6_ev;
		set1[`W1_SOLICIT_ANY] = solicit_any_reached_i; // see R12
		set1[`W1_UNEXPECTED_TEN] = u10_ev;
		set1[`W1_CLAIM_HEARD] = claim_ev;
		set1[`W1_NO_RESPONSE] = await_response_timeout_i; // see R20
		set1[`W1_WIN_SORT] = claim_won_i; // see R15
		set1[`W1_BUS_IDLE_EXPIRED] = idle_ev;
		set1[`W1_THRESHOLD_EXCEEDED] = tce_ev;
		set1[`W1_LOSE_SORT] = las_ev;
		set1[`W1_MODEM_ERROR] = modem_error_flag_ev;
	end
	// the request-pointer write must follow acceptance before the flag posts
	always @(posedge clk_i) begin
		if (reset_i) begin
			rwr_wait_reg <= 1'b0;
		end else if (rx_valid_rwr) begin
			rwr_wait_reg <= 1'b1; // see R2
		end else if (rwr_pointer_written_i) begin
			rwr_wait_reg <= 1'b0;
		end
	end
	// access machine actions, registered so every output is a flop
	always @(posedge clk_i) begin
		if (reset_i) begin
			go_offline_o <= 1'b0;
			go_idle_o <= 1'b0;
			solicit_any_send_o <= 1'b0;
			class6_start_o <= 1'b0;
			response_window_open_o <= 1'b0;
			class6_wait_reg <= 1'b0;
			successor_addr_o <= {ADDR_W{1'b0}};
		end else begin
			go_offline_o <= dup_ev || ftx_event || modem_error_flag_ev; // see R6, R7, R19
			go_idle_o <= u6_ev || u10_ev || las_ev; // see R11, R13, R18
			solicit_any_send_o <= solicit_any_reached_i; // see R12
			class6_start_o <= claim_won_i; // see R15
			// window opens only once class 6 traffic has gone out
			response_window_open_o <= class6_wait_reg && class6_done_i; // see R15
			if (claim_won_i) begin
				class6_wait_reg <= 1'b1;
			end else if (class6_done_i) begin
				class6_wait_reg <= 1'b0;
			end
			if (successor_update_i) begin
				successor_addr_o <= successor_new_i; // see R9
			end
		end
	end
	// pending events: a new event wins over the drop of the same bit
	always @(posedge clk_i) begin
		if (reset_i) begin
			pend0_reg <= 16'h0000;
			pend1_reg <= 16'h0000;
			clr_pend_reg <= 1'b0;
		end else begin
			pend0_reg <= (pend0_reg & ~drop0) | set0;
			pend1_reg <= (pend1_reg & ~drop1) | set1;
			clr_pend_reg <= (clr_pend_reg && !clr_done) || clear_status_i; // see R25
		end
	end
	// interrupt request holds until the vector fetch, a new cause wins
	always @(posedge clk_i) begin
		if (reset_i) begin
			irq_o <= 1'b0;
		end else if (irq_set) begin
			irq_o <= 1'b1; // see R21
		end else if (iack_i) begin
			irq_o <= 1'b0; // see R26
		end
	end
	// drop and interrupt strobes decoded from the sequencer state
	always @* begin
		drop0 = 16'h0000;
		drop1 = 16'h0000;
		irq_set = 1'b0;
		clr_done = (state_reg == S_CLR1) && mem_ack_i;
		if (mem_ack_i && ((state_reg == S_WR_STAT) ||
			(state_reg == S_RD_STAT && mem_rdata_i[bit_reg]))) begin
			drop1 = word_sel_reg ? one_hot(bit_reg) : 16'h0000;
			drop0 = word_sel_reg ? 16'h0000 : one_hot(bit_reg);
			irq_set = (state_reg == S_WR_STAT) && mask_bit_reg; // see R21
		end
	end
	// read-modify-write sequencer; a pending clear goes first, then word 1 ring events before word 0
	always @(posedge clk_i) begin
		if (reset_i) begin
			state_reg <= S_IDLE;
			mem_req_o <= 1'b0;
			mem_we_o <= 1'b0;
			mem_addr_o <= 8'h00;
			mem_wdata_o <= {DATA_W{1'b0}};
			word_sel_reg <= 1'b0;
			bit_reg <= 4'h0;
			stat_reg <= {DATA_W{1'b0}};
			mask_bit_reg <= 1'b0;
		end else begin
			case (state_reg)
			S_IDLE: begin
				if (clr_pend_reg) begin
					mem_req_o <= 1'b1;
					mem_we_o <= 1'b1;
					mem_addr_o <= `STATUS0_OFFSET;
					mem_wdata_o <= {DATA_W{1'b0}};
					state_reg <= S_CLR0;
				end else if (pend1_reg != 16'h0000) begin
					word_sel_reg <= 1'b1;
					bit_reg <= first_set(pend1_reg);
					mem_req_o <= 1'b1;
					mem_we_o <= 1'b0;
					mem_addr_o <= `STATUS1_OFFSET; // see R5
					state_reg <= S_RD_STAT;
				end else if (pend0_reg != 16'h0000) begin
					word_sel_reg <= 1'b0;
					bit_reg <= first_set(pend0_reg);
					mem_req_o <= 1'b1;
					mem_we_o <= 1'b0;
					mem_addr_o <= `STATUS0_OFFSET;
					state_reg <= S_RD_STAT;
				end
			end
			S_RD_STAT: begin
				if (mem_ack_i) begin
					stat_reg <= mem_rdata_i; // see R24
					if (mem_rdata_i[bit_reg]) begin
						// flag already up: leave memory untouched
						mem_req_o <= 1'b0;
						state_reg <= S_IDLE;
					end else begin
						mem_addr_o <= word_sel_reg ? `MASK1_OFFSET : `MASK0_OFFSET; // see R22, R23
						state_reg <= S_RD_MASK;
					end
				end
			end
			S_RD_MASK: begin
				if (mem_ack_i) begin
					// reserved mask bit never enables anything
					mask_bit_reg <= mem_rdata_i[bit_reg] &&
						!(word_sel_reg && bit_reg == `W1_RESERVED); // see R23
					mem_we_o <= 1'b1;
					mem_addr_o <= word_sel_reg ? `STATUS1_OFFSET : `STATUS0_OFFSET;
					mem_wdata_o <= stat_reg | one_hot(bit_reg); // see R24
					state_reg <= S_WR_STAT;
				end
			end
			S_WR_STAT: begin
				if (mem_ack_i) begin
					mem_req_o <= 1'b0;
					mem_we_o <= 1'b0;
					state_reg <= S_IDLE;
				end
			end
			S_CLR0: begin
				if (mem_ack_i) begin
					mem_addr_o <= `STATUS1_OFFSET; // see R25
					state_reg <= S_CLR1;
				end
			end
			S_CLR1: begin
				if (mem_ack_i) begin
					mem_req_o <= 1'b0;
					mem_we_o <= 1'b0;
					state_reg <= S_IDLE;
				end
			end
			default: begin
				mem_req_o <= 1'b0;
				mem_we_o <= 1'b0;
				state_reg <= S_IDLE;
			end
			endcase
		end
	end
endmodule

/* hw/token_bus_event_map.vh */
// offsets, bit positions and limits of the token bus event flag words
`ifndef TOKEN_BUS_EVENT_MAP_VH
`define TOKEN_BUS_EVENT_MAP_VH

// initialization table byte offsets
`define STATUS0_OFFSET 8'ha8
`define MASK0_OFFSET 8'haa
`define STATUS1_OFFSET 8'hac
`define MASK1_OFFSET 8'hae

// status word 0 and mask word 0 bit positions
`define W0_COMMAND_COMPLETE 4'h0
`define W0_FRAME_POOL_EMPTY 4'h1
`define W0_BUFFER_POOL_EMPTY 4'h2
`define W0_TX_QUEUE_EMPTY 4'h3
`define W0_TOKEN_SKIPPED 4'h4
`define W0_TOKEN_PASSED 4'h5
`define W0_BUS_ERROR 4'h6
`define W0_FRAME_POOL_LOW 4'h7
`define W0_BUFFER_POOL_LOW 4'h8
`define W0_FIFO_OVERRUN 4'h9
`define W0_FIFO_UNDERRUN 4'ha
`define W0_TX_REQUEST_DONE 4'hb
`define W0_TX_RESPONSE_DONE 4'hc
`define W0_TX_DATA_DONE 4'hd
`define W0_RX_REQUEST 4'he
`define W0_RX_DATA 4'hf

// status word 1 and mask word 1 bit positions
`define W1_DUPLICATE_ADDRESS 4'h0
`define W1_FAULTY_TRANSMITTER 4'h1
`define W1_SUCCESSOR_CHANGED 4'h2
`define W1_NO_SUCCESSOR 4'h3
`define W1_NO_SUCCESSOR_ONE 4'h4
`define W1_UNEXPECTED_SIX 4'h5
`define W1_SOLICIT_ANY 4'h6
`define W1_UNEXPECTED_TEN 4'h7
`define W1_CLAIM_HEARD 4'h8
`define W1_NO_RESPONSE 4'h9
`define W1_WIN_SORT 4'ha
`define W1_BUS_IDLE_EXPIRED 4'hb
`define W1_THRESHOLD_EXCEEDED 4'hc
`define W1_LOSE_SORT 4'hd
`define W1_RESERVED 4'he
`define W1_MODEM_ERROR 4'hf

// transmitter fault count limit, flag raised above it
`define TX_FAULT_LIMIT 4'h7
`define TX_FAULT_RESET 4'h0

`endif

/* hw/tx_fault_counter.v */
// transmitter fault counter with limit detection
`timescale 1ns/1ps
module tx_fault_counter #(
	parameter CNT_W = 4,
	parameter [CNT_W-1:0] LIMIT = 4'h7
) (
	input wire clk_i,
	input wire reset_i,
	input wire fail_i,
	input wire clear_i,
	output reg exceeded_o
);
	reg [CNT_W-1:0] count_reg;
	reg [CNT_W-1:0] count_next;

	// saturating count so the flag condition never wraps back to quiet
	always @* begin
		count_next = count_reg;
		if (clear_i) begin
			count_next = {CNT_W{1'b0}};
		end else if (fail_i && count_reg != {CNT_W{1'b1}}) begin
			count_next = count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// clear beats a simultaneous failure: another station heard us
	always @(posedge clk_i) begin
		if (reset_i) begin
			count_reg <= {CNT_W{1'b0}};
			exceeded_o <= 1'b0;
		end else begin
			count_reg <= count_next;
			exceeded_o <= !clear_i && fail_i && (count_next > LIMIT);
		end
	end
endmodule
